// ==== rtl/drive_cmd_pkg.sv ====
package drive_cmd_pkg;

  // ------------------------------------------------------------
  // object indices
  // ------------------------------------------------------------
  localparam logic [15:0] IDX_COMMAND_WORD = 16'h6040;
  localparam logic [15:0] IDX_STATE_WORD = 16'h6041;
  localparam logic [15:0] IDX_MODE_SELECT = 16'h6060;
  localparam logic [15:0] IDX_MODE_DISPLAY = 16'h6061;

  localparam logic [15:0] COMMAND_WORD_RST = 16'h0000;
  localparam logic [7:0] MODE_SELECT_RST = 8'h00;
  localparam logic [7:0] MODE_DISPLAY_RST = 8'h00;
  localparam logic [7:0] MODE_MAX = 8'h0A;

  // ------------------------------------------------------------
  // command word fields
  // ------------------------------------------------------------
  localparam int CW_SWITCH_ON = 0;
  localparam int CW_POWER = 1;
  localparam int CW_QSTOP_N = 2;
  localparam int CW_ENABLE_OP = 3;
  localparam int CW_MODE_LO = 4;
  localparam int CW_FAULT_RESET = 7;
  localparam int CW_HALT = 8;

  // ------------------------------------------------------------
  // operation modes
  // ------------------------------------------------------------
  localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
  localparam logic [7:0] MODE_PROFILE_TORQUE = 8'h04;
  localparam logic [7:0] MODE_PROFILE_VEL = 8'h03;
  localparam logic [7:0] MODE_HOMING = 8'h06;
  localparam logic [7:0] MODE_INTERP_POS = 8'h07;
  localparam logic [7:0] MODE_CYC_POS = 8'h08;
  localparam logic [7:0] MODE_CYC_VEL = 8'h09;
  localparam logic [7:0] MODE_CYC_TORQUE = 8'h0A;

  // ------------------------------------------------------------
  // state word patterns, bits 0..9
  // ------------------------------------------------------------
  localparam logic [15:0] SW_NOT_READY = 16'h0000;
  localparam logic [15:0] SW_SWITCH_DISABLED = 16'h0250;
  localparam logic [15:0] SW_READY = 16'h0231;
  localparam logic [15:0] SW_SWITCHED_ON = 16'h0233;
  localparam logic [15:0] SW_OP_ENABLED = 16'h0237;
  localparam logic [15:0] SW_QSTOP = 16'h0217;
  localparam logic [15:0] SW_FAULT_REACT = 16'h021F;
  localparam logic [15:0] SW_FAULT = 16'h0218;
  localparam int SW_WARNING = 7;
  localparam int SW_TARGET = 10;
  localparam int SW_LIMIT = 11;
  localparam int SW_MODE_LO = 12;
  localparam int SW_MODE_HI = 13;
  localparam int SW_HOMED = 15;

  typedef enum logic [7:0] {
    ST_NOT_READY = 8'h01,
    ST_SWITCH_DISABLED = 8'h02,
    ST_READY = 8'h04,
    ST_SWITCHED_ON = 8'h08,
    ST_OP_ENABLED = 8'h10,
    ST_QSTOP = 8'h20,
    ST_FAULT_REACT = 8'h40,
    ST_FAULT = 8'h80
  } drive_state_t;

  typedef enum logic [5:0] {
    CMD_NONE = 6'h01,
    CMD_SHUTDOWN = 6'h02,
    CMD_SWITCH_ON = 6'h04,
    CMD_ENABLE_OP = 6'h08,
    CMD_DISABLE_VOLT = 6'h10,
    CMD_QUICK_STOP = 6'h20
  } drive_cmd_t;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [15:0] wdata;
  } obj_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } obj_rsp_t;

  typedef struct packed {
    logic failure;
    logic react_done;
    logic qstop_done;
    logic qstop_resume;
    logic warning;
    logic target_reached;
    logic sw_limit;
    logic [1:0] mode_stat;
    logic homed;
  } drive_fb_t;

  typedef struct packed {
    logic power_on;
    logic op_enable;
    logic quick_stop;
    logic halt;
    logic fault_reset;
    logic pp_new_setpoint;
    logic pp_change_now;
    logic pp_relative;
    logic hm_start;
  } drive_ctl_t;

endpackage

// ==== rtl/drive_cmd_decode.sv ====
module drive_cmd_decode (
  // command word in
  input wire logic [15:0] cw_i,
  // decoded command out
  output drive_cmd_pkg::drive_cmd_t cmd_o
);

  logic [3:0] low;

  assign low = {cw_i[drive_cmd_pkg::CW_ENABLE_OP],
                cw_i[drive_cmd_pkg::CW_QSTOP_N],
                cw_i[drive_cmd_pkg::CW_POWER],
                cw_i[drive_cmd_pkg::CW_SWITCH_ON]};

  // priority order bit 1, bit 2, bit 0, bit 3; every value gives a command
  always_comb begin
    cmd_o = drive_cmd_pkg::CMD_NONE;
    if (!low[1]) begin
      cmd_o = drive_cmd_pkg::CMD_DISABLE_VOLT;
    end else if (!low[2]) begin
      cmd_o = drive_cmd_pkg::CMD_QUICK_STOP;
    end else if (!low[0]) begin
      cmd_o = drive_cmd_pkg::CMD_SHUTDOWN;
    end else if (!low[3]) begin
      cmd_o = drive_cmd_pkg::CMD_SWITCH_ON;
    end else begin
      cmd_o = drive_cmd_pkg::CMD_ENABLE_OP;
    end
  end

endmodule

// ==== rtl/drive_cmd_status.sv ====
// What this block does
// - bits 0,1,3 active high
// - bit 2 low requests quick stop
// - fault reset on bit7 rise; held blocks commands
// - bits 4..6 decoded per active mode
// - bit 8 halts using the mode pause
// - every bit pattern forms a command, by priority
// - not ready and switch disabled patterns
// - ready, switched on, enabled patterns
// - quick stop, fault reaction, fault patterns
// - state bits 12,13 depend on mode
// - bits 10,11,15 same in every mode
// - mode selector writable, values 0..10
// - mode codes 1,3,6,8,9,10 decoded
// - modes 4 and 7 not supported
// - read-only display of mode in effect
// - 6,7,F,2,0 command words walk states
// - failure enters fault reaction, then fault
module drive_cmd_status #(
  parameter int CW_W = 16
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // object access port
  input drive_cmd_pkg::obj_req_t obj_req_i,
  output drive_cmd_pkg::obj_rsp_t obj_rsp_o,
  // drive feedback and control
  input drive_cmd_pkg::drive_fb_t fb_i,
  output drive_cmd_pkg::drive_ctl_t ctl_o,
  // snapshots
  output logic [15:0] state_word_o,
  output logic [7:0] mode_display_o
);

  if (CW_W != 16) begin : g_check
    $error("command word width must be 16");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    drive_cmd_pkg::drive_state_t st;
    logic [15:0] cw;
    logic [7:0] mode_sel;
    logic [7:0] mode_disp;
    logic bit7_prev;
    logic [15:0] sw;
    drive_cmd_pkg::obj_rsp_t rsp;
    drive_cmd_pkg::drive_ctl_t ctl;
  } core_t;

  core_t s_reg;
  core_t s_next;
  drive_cmd_pkg::drive_cmd_t cmd;

  drive_cmd_decode u_decode (
    .cw_i(s_reg.cw),
    .cmd_o(cmd)
  );

  function automatic logic mode_ok(input logic [7:0] m);
    unique case (m)
      drive_cmd_pkg::MODE_PROFILE_POS,
      drive_cmd_pkg::MODE_PROFILE_VEL,
      drive_cmd_pkg::MODE_HOMING,
      drive_cmd_pkg::MODE_CYC_POS,
      drive_cmd_pkg::MODE_CYC_VEL,
      drive_cmd_pkg::MODE_CYC_TORQUE: mode_ok = 1'b1;
      // profile torque, interpolation and reserved codes refused
      default: mode_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] pattern(
    input drive_cmd_pkg::drive_state_t st
  );
    unique case (st)
      drive_cmd_pkg::ST_NOT_READY: pattern = drive_cmd_pkg::SW_NOT_READY;
      drive_cmd_pkg::ST_SWITCH_DISABLED: begin
        pattern = drive_cmd_pkg::SW_SWITCH_DISABLED;
      end
      drive_cmd_pkg::ST_READY: pattern = drive_cmd_pkg::SW_READY;
      drive_cmd_pkg::ST_SWITCHED_ON: begin
        pattern = drive_cmd_pkg::SW_SWITCHED_ON;
      end
      drive_cmd_pkg::ST_OP_ENABLED: begin
        pattern = drive_cmd_pkg::SW_OP_ENABLED;
      end
      drive_cmd_pkg::ST_QSTOP: pattern = drive_cmd_pkg::SW_QSTOP;
      drive_cmd_pkg::ST_FAULT_REACT: begin
        pattern = drive_cmd_pkg::SW_FAULT_REACT;
      end
      drive_cmd_pkg::ST_FAULT: pattern = drive_cmd_pkg::SW_FAULT;
      default: pattern = drive_cmd_pkg::SW_NOT_READY;
    endcase
  endfunction

  logic bit7;
  logic reset_edge;
  logic [7:0] wmode;

  assign bit7 = s_reg.cw[drive_cmd_pkg::CW_FAULT_RESET];
  assign reset_edge = bit7 && !s_reg.bit7_prev;
  assign wmode = obj_req_i.wdata[7:0];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.bit7_prev = bit7;
    s_next.rsp = '0;

    // object access: one cycle answer to each request
    if (obj_req_i.wr) begin
      s_next.rsp.ack = 1'b1;
      unique case (obj_req_i.index)
        drive_cmd_pkg::IDX_COMMAND_WORD: s_next.cw = obj_req_i.wdata;
        drive_cmd_pkg::IDX_MODE_SELECT: begin
          // selector is signed 8 bit; outside 0..10 refused
          if (obj_req_i.wdata[15:8] == 8'h00 &&
              wmode <= drive_cmd_pkg::MODE_MAX) begin
            s_next.mode_sel = wmode;
          end else begin
            s_next.rsp.err = 1'b1;
          end
        end
        default: s_next.rsp.err = 1'b1;
      endcase
    end else if (obj_req_i.rd) begin
      s_next.rsp.ack = 1'b1;
      unique case (obj_req_i.index)
        drive_cmd_pkg::IDX_COMMAND_WORD: s_next.rsp.rdata = s_reg.cw;
        drive_cmd_pkg::IDX_STATE_WORD: s_next.rsp.rdata = s_reg.sw;
        drive_cmd_pkg::IDX_MODE_SELECT: begin
          s_next.rsp.rdata = {8'h00, s_reg.mode_sel};
        end
        drive_cmd_pkg::IDX_MODE_DISPLAY: begin
          s_next.rsp.rdata = {8'h00, s_reg.mode_disp};
        end
        default: s_next.rsp.err = 1'b1;
      endcase
    end

    // mode in effect follows a supported selector only
    if (mode_ok(s_reg.mode_sel)) begin
      s_next.mode_disp = s_reg.mode_sel;
    end // otherwise display keeps its value

    // state machine; the master keeps the command order
    unique case (s_reg.st)
      drive_cmd_pkg::ST_NOT_READY: begin
        s_next.st = drive_cmd_pkg::ST_SWITCH_DISABLED;
      end
      drive_cmd_pkg::ST_FAULT_REACT: begin
        if (fb_i.react_done) begin
          s_next.st = drive_cmd_pkg::ST_FAULT;
        end
      end
      drive_cmd_pkg::ST_FAULT: begin
        if (reset_edge) begin
          s_next.st = drive_cmd_pkg::ST_SWITCH_DISABLED;
        end
      end
      default: begin
        // held reset bit freezes every other command
        if (!bit7) begin
          unique case (s_reg.st)
            drive_cmd_pkg::ST_SWITCH_DISABLED: begin
              if (cmd == drive_cmd_pkg::CMD_SHUTDOWN) begin
                s_next.st = drive_cmd_pkg::ST_READY;
              end
            end
            drive_cmd_pkg::ST_READY: begin
              if (cmd == drive_cmd_pkg::CMD_SWITCH_ON) begin
                s_next.st = drive_cmd_pkg::ST_SWITCHED_ON;
              end else if (cmd == drive_cmd_pkg::CMD_DISABLE_VOLT ||
                           cmd == drive_cmd_pkg::CMD_QUICK_STOP) begin
                s_next.st = drive_cmd_pkg::ST_SWITCH_DISABLED;
              end
            end
            drive_cmd_pkg::ST_SWITCHED_ON: begin
              if (cmd == drive_cmd_pkg::CMD_ENABLE_OP) begin
                s_next.st = drive_cmd_pkg::ST_OP_ENABLED;
              end else if (cmd == drive_cmd_pkg::CMD_SHUTDOWN) begin
                s_next.st = drive_cmd_pkg::ST_READY;
              end else if (cmd == drive_cmd_pkg::CMD_DISABLE_VOLT ||
                           cmd == drive_cmd_pkg::CMD_QUICK_STOP) begin
                s_next.st = drive_cmd_pkg::ST_SWITCH_DISABLED;
              end
            end
            drive_cmd_pkg::ST_OP_ENABLED: begin
              if (cmd == drive_cmd_pkg::CMD_SWITCH_ON) begin
                s_next.st = drive_cmd_pkg::ST_SWITCHED_ON;
              end else if (cmd == drive_cmd_pkg::CMD_SHUTDOWN) begin
                s_next.st = drive_cmd_pkg::ST_READY;
              end else if (cmd == drive_cmd_pkg::CMD_QUICK_STOP) begin
                s_next.st = drive_cmd_pkg::ST_QSTOP;
              end else if (cmd == drive_cmd_pkg::CMD_DISABLE_VOLT) begin
                s_next.st = drive_cmd_pkg::ST_SWITCH_DISABLED;
              end
            end
            drive_cmd_pkg::ST_QSTOP: begin
              if (cmd == drive_cmd_pkg::CMD_DISABLE_VOLT) begin
                s_next.st = drive_cmd_pkg::ST_SWITCH_DISABLED;
              end else if (fb_i.qstop_done && !fb_i.qstop_resume) begin
                s_next.st = drive_cmd_pkg::ST_SWITCH_DISABLED;
              end else if (fb_i.qstop_done &&
                           cmd == drive_cmd_pkg::CMD_ENABLE_OP) begin
                s_next.st = drive_cmd_pkg::ST_OP_ENABLED;
              end
            end
            default: s_next.st = drive_cmd_pkg::ST_NOT_READY;
          endcase
        end
        // failure outranks any command in the same cycle
        if (fb_i.failure) begin
          s_next.st = drive_cmd_pkg::ST_FAULT_REACT;
        end
      end
    endcase

    // state word built from the next state, no stale mix
    s_next.sw = pattern(s_next.st);
    if (s_next.st != drive_cmd_pkg::ST_NOT_READY) begin
      s_next.sw[drive_cmd_pkg::SW_WARNING] = fb_i.warning;
      s_next.sw[drive_cmd_pkg::SW_TARGET] = fb_i.target_reached;
      s_next.sw[drive_cmd_pkg::SW_LIMIT] = fb_i.sw_limit;
      s_next.sw[drive_cmd_pkg::SW_HOMED] = fb_i.homed;
      s_next.sw[drive_cmd_pkg::SW_MODE_HI:drive_cmd_pkg::SW_MODE_LO] =
        fb_i.mode_stat;
    end

    // control outputs
    s_next.ctl = '0;
    s_next.ctl.fault_reset = (s_reg.st == drive_cmd_pkg::ST_FAULT) &&
                             reset_edge;
    s_next.ctl.power_on = s_next.st inside {drive_cmd_pkg::ST_SWITCHED_ON,
      drive_cmd_pkg::ST_OP_ENABLED, drive_cmd_pkg::ST_QSTOP};
    s_next.ctl.quick_stop = s_next.st == drive_cmd_pkg::ST_QSTOP;
    if (s_next.st == drive_cmd_pkg::ST_OP_ENABLED) begin
      s_next.ctl.op_enable = 1'b1;
      s_next.ctl.halt = s_reg.cw[drive_cmd_pkg::CW_HALT];
      // bits 4..6 read in the light of the mode in effect
      unique case (s_reg.mode_disp)
        drive_cmd_pkg::MODE_PROFILE_POS: begin
          s_next.ctl.pp_new_setpoint = s_reg.cw[drive_cmd_pkg::CW_MODE_LO];
          s_next.ctl.pp_change_now =
            s_reg.cw[drive_cmd_pkg::CW_MODE_LO + 1];
          s_next.ctl.pp_relative =
            s_reg.cw[drive_cmd_pkg::CW_MODE_LO + 2];
        end
        drive_cmd_pkg::MODE_HOMING: begin
          s_next.ctl.hm_start = s_reg.cw[drive_cmd_pkg::CW_MODE_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg.st <= drive_cmd_pkg::ST_NOT_READY;
      s_reg.cw <= drive_cmd_pkg::COMMAND_WORD_RST;
      s_reg.mode_sel <= drive_cmd_pkg::MODE_SELECT_RST;
      s_reg.mode_disp <= drive_cmd_pkg::MODE_DISPLAY_RST;
      s_reg.bit7_prev <= 1'b0;
      s_reg.sw <= drive_cmd_pkg::SW_NOT_READY;
      s_reg.rsp <= '0;
      s_reg.ctl <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign obj_rsp_o = s_reg.rsp;
  assign ctl_o = s_reg.ctl;
  assign state_word_o = s_reg.sw;
  assign mode_display_o = s_reg.mode_disp;

endmodule

// ==== testbench/drive_cmd_status_chk.sv ====
module drive_cmd_status_chk (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // watched ports
  input drive_cmd_pkg::obj_req_t obj_req_i,
  input drive_cmd_pkg::obj_rsp_t obj_rsp_o,
  input drive_cmd_pkg::drive_fb_t fb_i,
  input drive_cmd_pkg::drive_ctl_t ctl_o,
  input wire logic [15:0] state_word_o,
  input wire logic [7:0] mode_display_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic req;
  logic [3:0] st;
  assign req = obj_req_i.wr | obj_req_i.rd;
  assign st = state_word_o[3:0];
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_ack;
    req |=> obj_rsp_o.ack;
  endproperty
  property p_ro_refused;
    obj_req_i.wr && obj_req_i.index inside {16'h6041, 16'h6061}
      |=> obj_rsp_o.err;
  endproperty
  property p_sel_range;
    obj_req_i.wr && obj_req_i.index == 16'h6060 && obj_req_i.wdata > 16'h000A
      |=> obj_rsp_o.ack && obj_rsp_o.err;
  endproperty
  property p_pattern;
    (state_word_o & 16'h037F) inside {16'h0000, 16'h0250, 16'h0231,
      16'h0233, 16'h0237, 16'h0217, 16'h021F, 16'h0218};
  endproperty
  property p_fault_entry;
    fb_i.failure && st inside {4'h1, 4'h3, 4'h7} |=> st == 4'hF;
  endproperty
  property p_fault_done;
    st == 4'hF && fb_i.react_done |=> st == 4'h8;
  endproperty
  property p_reset_pulse;
    ctl_o.fault_reset |-> ($past(st) == 4'h8 && st == 4'h0 &&
      state_word_o[6]) ##1 !ctl_o.fault_reset;
  endproperty
  property p_halt;
    ctl_o.halt |-> st == 4'h7 && state_word_o[5];
  endproperty
  property p_display;
    mode_display_o inside {8'h00, 8'h01, 8'h03, 8'h06, 8'h08, 8'h09, 8'h0A};
  endproperty
  property p_fb_bits;
    {state_word_o[15], state_word_o[13:10]} == $past({fb_i.homed,
      fb_i.mode_stat, fb_i.sw_limit, fb_i.target_reached});
  endproperty
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_ack: assert property (p_ack)
    else $error("request without answer");
  a_ro_refused: assert property (p_ro_refused)
    else $error("write to read-only object accepted");
  a_sel_range: assert property (p_sel_range)
    else $error("mode selector out of range accepted");
  a_pattern: assert property (p_pattern)
    else $error("state word pattern illegal");
  a_fault_entry: assert property (p_fault_entry)
    else $error("failure did not start fault reaction");
  a_fault_done: assert property (p_fault_done)
    else $error("fault reaction did not end in fault");
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("fault reset pulse out of place");
  a_halt: assert property (p_halt)
    else $error("halt outside operation enabled");
  a_display: assert property (p_display)
    else $error("mode display holds unsupported code");
  a_fb_bits: assert property (p_fb_bits)
    else $error("feedback bits not reported");
  c_fault_reset: cover property (ctl_o.fault_reset);
  c_err: cover property (obj_rsp_o.err);
  c_qstop: cover property (st == 4'h7 && !state_word_o[5]);
endmodule

// ==== testbench/bus_master_model.sv ====
module bus_master_model (
  // clock
  input wire logic ref_clk_i,
  // object port
  output drive_cmd_pkg::obj_req_t req_o,
  input drive_cmd_pkg::obj_rsp_t rsp_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_o = '{wr: 1'b0, rd: 1'b0, index: 16'hFFFF, wdata: 16'hFFFF};
  // one-cycle request; the answer stands only in the cycle after the
  // taking edge, so it is picked up before the request is dropped
  task automatic access(input logic w, input logic [15:0] idx, wd,
      output drive_cmd_pkg::obj_rsp_t rsp);
    @(negedge ref_clk_i);
    req_o = '{wr: w, rd: !w, index: idx, wdata: wd};
    @(negedge ref_clk_i);
    rsp = rsp_i;
    // idle lines never repeat the last value
    req_o = '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: ~wd};
  endtask
endmodule

// ==== testbench/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i;
  logic rstn_i;
  drive_cmd_pkg::obj_req_t req;
  drive_cmd_pkg::obj_rsp_t rsp_w;
  drive_cmd_pkg::obj_rsp_t rsp;
  drive_cmd_pkg::drive_fb_t fb;
  drive_cmd_pkg::drive_ctl_t ctl;
  logic [15:0] sw;
  logic [7:0] disp_w;
  int n_fail;
  int cmp_count;

  drive_cmd_status drive_cmd_status_inst (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .obj_req_i(req), .obj_rsp_o(rsp_w), .fb_i(fb),
    .ctl_o(ctl), .state_word_o(sw), .mode_display_o(disp_w));
  bus_master_model bus_master_model_inst (.ref_clk_i(ref_clk_i),
    .req_o(req), .rsp_i(rsp_w));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [15:0] idx, wd,
      input logic e, input logic [15:0] rd);
    bus_master_model_inst.access(w, idx, wd, rsp);
    chk({14'h0, rsp.ack, rsp.err}, {14'h0, 1'b1, e});
    if (!w) chk(rsp.rdata, rd);
  endtask

  // command word write, state word looked at once it has moved
  task automatic cmd(input logic [15:0] cw, input logic [15:0] exp);
    acc(1'b1, 16'h6040, cw, 1'b0, 16'h0);
    @(negedge ref_clk_i);
    chk(sw, exp);
  endtask

  task automatic t_regs();
    acc(1'b0, 16'h6040, 16'h0, 1'b0, drive_cmd_pkg::COMMAND_WORD_RST);
    acc(1'b0, 16'h6060, 16'h0, 1'b0, 16'h0000);
    acc(1'b0, 16'h6061, 16'h0, 1'b0, 16'h0000);
    acc(1'b0, 16'h6041, 16'h0, 1'b0, 16'h0250);
    acc(1'b1, 16'h6041, 16'h1234, 1'b1, 16'h0);
    acc(1'b1, 16'h6061, 16'h0001, 1'b1, 16'h0);
    acc(1'b0, 16'h6042, 16'h0, 1'b1, 16'h0);
    $display("test regs done");
  endtask

  task automatic t_walk();
    cmd(16'h0008, 16'h0250);
    cmd(16'h0006, 16'h0231);
    cmd(16'h000B, 16'h0250);
    cmd(16'h0006, 16'h0231);
    cmd(16'h0007, 16'h0233);
    cmd(16'h000F, 16'h0237);
    chk({14'h0, ctl.power_on, ctl.op_enable}, 16'h3);
    cmd(16'h0007, 16'h0233);
    cmd(16'h0006, 16'h0231);
    cmd(16'h0007, 16'h0233);
    cmd(16'h000F, 16'h0237);
    cmd(16'h0000, 16'h0250);
    $display("test walk done");
  endtask

  task automatic t_qstop();
    cmd(16'h0006, 16'h0231);
    cmd(16'h0007, 16'h0233);
    cmd(16'h000F, 16'h0237);
    cmd(16'h0002, 16'h0217);
    chk({15'h0, ctl.quick_stop}, 16'h1);
    fb.qstop_done = 1'b1;
    @(negedge ref_clk_i);
    chk(sw, 16'h0250);
    fb.qstop_done = 1'b0;
    cmd(16'h0006, 16'h0231);
    cmd(16'h0007, 16'h0233);
    cmd(16'h000F, 16'h0237);
    fb.qstop_resume = 1'b1;
    cmd(16'h0002, 16'h0217);
    fb.qstop_done = 1'b1;
    @(negedge ref_clk_i);
    chk(sw, 16'h0217);
    cmd(16'h000F, 16'h0237);
    fb = '0;
    $display("test quick stop done");
  endtask

  task automatic t_fault();
    cmd(16'h0006, 16'h0231);
    fb.failure = 1'b1;
    @(negedge ref_clk_i);
    chk(sw, 16'h021F);
    @(negedge ref_clk_i);
    chk(sw, 16'h021F);
    fb.failure = 1'b0;
    fb.react_done = 1'b1;
    @(negedge ref_clk_i);
    chk(sw, 16'h0218);
    fb.react_done = 1'b0;
    cmd(16'h0006, 16'h0218);
    cmd(16'h0080, 16'h0250);
    chk({15'h0, ctl.fault_reset}, 16'h1);
    @(negedge ref_clk_i);
    chk({15'h0, ctl.fault_reset}, 16'h0);
    cmd(16'h0086, 16'h0250);
    cmd(16'h0006, 16'h0231);
    $display("test fault done");
  endtask

  task automatic t_mode();
    logic [7:0] disp;
    disp = 8'h00;
    for (int m = 0; m <= 11; m++) begin
      acc(1'b1, 16'h6060, 16'(m), m > 10, 16'h0);
      if (m inside {1, 3, 6, 8, 9, 10}) disp = 8'(m);
      @(negedge ref_clk_i);
      acc(1'b0, 16'h6061, 16'h0, 1'b0, {8'h00, disp});
    end
    acc(1'b1, 16'h6060, 16'h0101, 1'b1, 16'h0);
    acc(1'b0, 16'h6060, 16'h0, 1'b0, 16'h000A);
    $display("test mode done");
  endtask

  task automatic t_bits();
    acc(1'b1, 16'h6060, 16'h0001, 1'b0, 16'h0);
    cmd(16'h0007, 16'h0233);
    cmd(16'h005F, 16'h0237);
    chk({11'h0, ctl.pp_new_setpoint, ctl.pp_change_now, ctl.pp_relative,
      ctl.halt, ctl.hm_start}, 16'h0014);
    cmd(16'h011F, 16'h0237);
    chk({15'h0, ctl.halt}, 16'h1);
    acc(1'b1, 16'h6060, 16'h0006, 1'b0, 16'h0);
    @(negedge ref_clk_i);
    cmd(16'h001F, 16'h0237);
    chk({11'h0, ctl.pp_new_setpoint, ctl.pp_change_now, ctl.pp_relative,
      ctl.halt, ctl.hm_start}, 16'h0001);
    fb = '{warning: 1'b1, target_reached: 1'b1, sw_limit: 1'b1,
      mode_stat: 2'b11, homed: 1'b1, default: 1'b0};
    @(negedge ref_clk_i);
    chk(sw, 16'hBEB7);
    fb = '0;
    cmd(16'h0000, 16'h0250);
    $display("test mode bits done");
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    rstn_i = 1'b0;
    fb = '0;
    n_fail = 0;
    cmp_count = 0;
    repeat (12) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    @(negedge ref_clk_i);
    t_regs();
    t_walk();
    t_qstop();
    t_fault();
    t_mode();
    t_bits();
    results();
  end

  // whole run needs well under 1000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    results();
  end
endmodule

bind drive_cmd_status drive_cmd_status_chk drive_cmd_status_chk_inst (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .obj_req_i(obj_req_i),
  .obj_rsp_o(obj_rsp_o), .fb_i(fb_i), .ctl_o(ctl_o),
  .state_word_o(state_word_o), .mode_display_o(mode_display_o));
